//--- tb/gpio_power_model.sv
// Purpose: Pin and power-mode side of the power sequencer
// Assumes: Pins toggle only on request, one change per call
// Notes: Changes land just after a rising edge
`timescale 1ns/1ps
`include "pwr_seq_defines.svh"
module gpio_power_model (
	input wire logic clk,
	output logic [`PIN_COUNT-1:0] pin_level,
	output logic [1:0] power_mode
);
	initial begin
		pin_level = '0;
		power_mode = pwr_seq_pkg::PM_ACTIVE;
	end

	// Each call is one transition, direction alternates per pin
	task automatic flip(input int pin);
		@(posedge clk);
		pin_level[pin] <= ~pin_level[pin];
	endtask

	task automatic enter_mode(input logic [1:0] m);
		@(posedge clk);
		power_mode <= m;
	endtask
endmodule

//--- tb/testbench.sv
// Purpose: Register-level checks of the power sequencer control block
// Assumes: Read data valid only in the cycle after the read strobe
// Notes: Outputs checked three edges after a write or pin change
`timescale 1ns/1ps
`include "pwr_seq_defines.svh"
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [`PIN_COUNT-1:0] pin_level;
	logic [1:0] power_mode;
	logic core_por_block, bandgap_off, quick_wake, retention_reg_on, supply_detect_bypass;
	logic [1:0] voltage_range;
	logic [3:0] ram_retain, ram_power_off;
	logic pin_wake_irq, wake_request, irq;
	logic [10:0] outs;
	logic [2:0] ints;
	int fail_count = 0;
	int checks_done = 0;

	assign outs = {core_por_block, bandgap_off, quick_wake, retention_reg_on, supply_detect_bypass,
		voltage_range, ram_retain};
	assign ints = {pin_wake_irq, wake_request, irq};

	always #4 clk = ~clk;

	gpio_power_model pm_u (.clk(clk), .pin_level(pin_level), .power_mode(power_mode));

	pwr_seq_ctrl dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .pin_level(pin_level), .power_mode(power_mode),
		.core_por_block(core_por_block), .bandgap_off(bandgap_off), .quick_wake(quick_wake),
		.retention_reg_on(retention_reg_on), .supply_detect_bypass(supply_detect_bypass),
		.voltage_range(voltage_range), .ram_retain(ram_retain), .ram_power_off(ram_power_off),
		.pin_wake_irq(pin_wake_irq), .wake_request(wake_request), .irq(irq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Whole run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		settle();
		chk(outs, {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'b10, 4'h0});
		reg_rd(`CTRL_OFF, 32'h00001920);
		reg_rd(`FLAG_OFF, 32'h0);
		reg_rd(`WAKE_EN_OFF, 32'h0);
		reg_rd(`RAM_SHUTDOWN_OFF, 32'h0);
		pm_u.enter_mode(pwr_seq_pkg::PM_DEEP);
		settle();
		chk(outs, {1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'b10, 4'h0});
		// Bit 9 reads back 0, so writing 0 preserves it
		reg_wr(`CTRL_OFF, 32'h0000045F);
		settle();
		chk(outs, {1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'b01, 4'h0});
		reg_rd(`CTRL_OFF, 32'h0000045F);
		reg_wr(`CTRL_OFF, 32'h00001D7F);
		reg_rd(`CTRL_OFF, 32'h00001D5F);
		pm_u.enter_mode(pwr_seq_pkg::PM_STATE_A);
		settle();
		chk(outs, {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'b01, 4'hF});
		reg_wr(`RAM_SHUTDOWN_OFF, 32'h0000000A);
		settle();
		chk({28'h0, ram_power_off}, 32'h0000000A);
		reg_rd(`RAM_SHUTDOWN_OFF, 32'h0000000A);
		reg_rd(8'h20, 32'h0);
		reg_wr(`INT_MASK_OFF, 32'h00000003);
		reg_wr(`WAKE_EN_OFF, 32'h00000008);
		reg_wr(`GLOBAL_WAKE_OFF, 32'h00000001);
		pm_u.enter_mode(pwr_seq_pkg::PM_SLEEP);
		// Rising then falling edge on the same pin
		for (int k = 0; k < 2; k++) begin
			pm_u.flip(3);
			settle();
			chk({29'h0, ints}, 32'h7);
			reg_rd(`FLAG_OFF, 32'h00000008);
			reg_rd(`INT_STAT_OFF, 32'h00000003);
			settle();
			chk({29'h0, ints}, 32'h6);
			reg_wr(`FLAG_OFF, 32'h00000008);
			settle();
			reg_rd(`FLAG_OFF, 32'h0);
			chk({29'h0, ints}, 32'h0);
		end
		pm_u.flip(5);
		settle();
		chk({29'h0, ints}, 32'h1);
		reg_rd(`FLAG_OFF, 32'h00000020);
		reg_rd(`INT_STAT_OFF, 32'h00000001);
		reg_wr(`INT_MASK_OFF, 32'h0);
		reg_wr(`WAKE_EN_OFF, 32'h00000028);
		settle();
		chk({29'h0, ints}, 32'h6);
		pm_u.enter_mode(pwr_seq_pkg::PM_ACTIVE);
		settle();
		chk({29'h0, ints}, 32'h4);
		reg_wr(`GLOBAL_WAKE_OFF, 32'h0);
		pm_u.enter_mode(pwr_seq_pkg::PM_SLEEP);
		settle();
		chk({29'h0, ints}, 32'h4);
		reg_wr(`FLAG_OFF, 32'h0);
		reg_rd(`FLAG_OFF, 32'h00000020);
		print_verdict();
	end
endmodule

//--- verilog/pin_toggle_detect.sv
// Purpose: Per-pin transition detection in either direction
// Assumes: Pin levels already synchronous to clk
// Notes: First sample after reset only primes the history
`timescale 1ns/1ps
module pin_toggle_detect #(parameter int PINS = 14) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [PINS-1:0] pin_level,
	pin_wake_if.detector wk
);
	typedef struct packed {
		logic [PINS-1:0] prev;
		logic primed;
	} det_state_s;

	det_state_s q;
	det_state_s d;

	// Without priming, a pin high at reset release would fake a toggle
	genvar i;
	generate
		for (i = 0; i < PINS; i++) begin : g_pin
			assign wk.toggle[i] = q.primed & (pin_level[i] ^ q.prev[i]);
		end
	endgenerate

	always_comb begin
		d = q;
		d.prev = pin_level;
		d.primed = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	chk_toggle_edge: assert property (@(posedge clk) disable iff (!reset_n)
		(q.primed && pin_level != $past(pin_level)) |-> (wk.toggle == (pin_level ^ $past(pin_level))))
		else $error("Pin change not reported as toggle");
endmodule

//--- verilog/pin_wake_if.sv
// Purpose: Carries pin toggles, flag clears and flag state between modules
// Assumes: One clock domain
// Notes: Plain wires, no clocking
`timescale 1ns/1ps
interface pin_wake_if #(parameter int PINS = 14);
	logic [PINS-1:0] toggle;
	logic [PINS-1:0] clr;
	logic [PINS-1:0] flags;
	modport detector (output toggle);
	modport bank (input toggle, input clr, output flags);
	modport owner (input toggle, output clr, input flags);
endinterface

//--- verilog/pwr_seq_ctrl.sv
// Purpose: Always-on power sequencer control and pin wake logic
// Assumes: reset_n is the power-on reset; register port strobes are one cycle
// Notes: Read data stand one cycle after the read strobe; unmapped reads give zero
`timescale 1ns/1ps
`include "pwr_seq_defines.svh"
module pwr_seq_ctrl (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic [`PIN_COUNT-1:0] pin_level,
	input wire logic [1:0] power_mode,
	output logic core_por_block,
	output logic bandgap_off,
	output logic quick_wake,
	output logic retention_reg_on,
	output logic supply_detect_bypass,
	output logic [1:0] voltage_range,
	output logic [`BANK_COUNT-1:0] ram_retain,
	output logic [`BANK_COUNT-1:0] ram_power_off,
	output logic pin_wake_irq,
	output logic wake_request,
	output logic irq
);
	pwr_seq_pkg::ctrl_state_s q;
	pwr_seq_pkg::ctrl_state_s d;
	pwr_seq_pkg::power_mode_e mode;

	pin_wake_if #(.PINS(`PIN_COUNT)) wk ();

	pin_toggle_detect #(.PINS(`PIN_COUNT)) u_detect (
		.clk(clk),
		.reset_n(reset_n),
		.pin_level(pin_level),
		.wk(wk.detector)
	);

	wake_flag_bank #(.PINS(`PIN_COUNT)) u_flags (
		.clk(clk),
		.reset_n(reset_n),
		.wk(wk.bank)
	);

	function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
		hit = strobe && (a == off);
	endfunction

	logic ctrl_wr;
	logic flag_wr;
	logic stat_rd;
	logic deep_or_state_a;
	logic deep_only;
	logic state_a_only;
	logic low_power;
	logic any_enabled;
	logic [`EVENT_COUNT-1:0] events;
	logic [31:0] ctrl_new;

	assign mode = pwr_seq_pkg::power_mode_e'(power_mode);
	assign ctrl_wr = hit(wr_en, addr, `CTRL_OFF);
	assign flag_wr = hit(wr_en, addr, `FLAG_OFF);
	assign stat_rd = hit(rd_en, addr, `INT_STAT_OFF);

	// Write 1 clears; the bank lets a same-cycle toggle win
	assign wk.clr = flag_wr ? wdata[`PIN_COUNT-1:0] : '0;

	always_comb begin
		deep_or_state_a = 1'b0;
		deep_only = 1'b0;
		state_a_only = 1'b0;
		low_power = 1'b1;
		case (mode)
			pwr_seq_pkg::PM_ACTIVE: begin
				low_power = 1'b0;
			end
			pwr_seq_pkg::PM_SLEEP: begin
				low_power = 1'b1;
			end
			pwr_seq_pkg::PM_DEEP: begin
				deep_or_state_a = 1'b1;
				deep_only = 1'b1;
			end
			pwr_seq_pkg::PM_STATE_A: begin
				deep_or_state_a = 1'b1;
				state_a_only = 1'b1;
			end
			default: begin
				low_power = 1'b0;
			end
		endcase
	end

	assign any_enabled = |(wk.flags & q.wake_en[`PIN_COUNT-1:0]);
	assign events[`EV_TOGGLE_BIT] = |wk.toggle;
	assign events[`EV_ENABLED_BIT] = |(wk.toggle & q.wake_en[`PIN_COUNT-1:0]);

	// Reserved voltage code is refused so the regulator never sees it
	always_comb begin
		ctrl_new = (q.ctrl & ~`CTRL_WMASK) | (wdata & `CTRL_WMASK);
		if (ctrl_new[`VRANGE_LSB+:2] == `VRANGE_RESERVED) begin
			ctrl_new[`VRANGE_LSB+:2] = q.ctrl[`VRANGE_LSB+:2];
		end
	end

	always_comb begin
		d = q;
		if (ctrl_wr) begin
			d.ctrl = ctrl_new;
		end
		if (hit(wr_en, addr, `WAKE_EN_OFF)) begin
			d.wake_en = wdata;
		end
		if (hit(wr_en, addr, `GLOBAL_WAKE_OFF)) begin
			d.global_wake = wdata[0];
		end
		if (hit(wr_en, addr, `RAM_SHUTDOWN_OFF)) begin
			d.ram_off = wdata[`BANK_COUNT-1:0];
		end
		if (hit(wr_en, addr, `INT_MASK_OFF)) begin
			d.int_mask = wdata[`EVENT_COUNT-1:0];
		end
		// Read clears, but an event in the same cycle survives
		d.int_stat = (stat_rd ? '0 : q.int_stat) | events;
		d.irq = |(d.int_stat & d.int_mask);

		d.rdata = '0;
		if (rd_en) begin
			case (addr)
				`CTRL_OFF: begin
					d.rdata = q.ctrl;
				end
				`FLAG_OFF: begin
					d.rdata = {{(32-`PIN_COUNT){1'b0}}, wk.flags};
				end
				`WAKE_EN_OFF: begin
					d.rdata = q.wake_en;
				end
				`GLOBAL_WAKE_OFF: begin
					d.rdata = {31'h0, q.global_wake};
				end
				`INT_STAT_OFF: begin
					d.rdata = {{(32-`EVENT_COUNT){1'b0}}, q.int_stat};
				end
				`INT_MASK_OFF: begin
					d.rdata = {{(32-`EVENT_COUNT){1'b0}}, q.int_mask};
				end
				`RAM_SHUTDOWN_OFF: begin
					d.rdata = {{(32-`BANK_COUNT){1'b0}}, q.ram_off};
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end

		// Outputs follow the stored control word, the present power mode and the enabled wake flags
		d.core_por_block = d.ctrl[`POR_BLOCK_BIT] & deep_or_state_a;
		d.bandgap_off = d.ctrl[`BANDGAP_BIT] & deep_or_state_a;
		d.quick_wake = d.ctrl[`QUICK_WAKE_BIT] & deep_only;
		d.retention_reg_on = d.ctrl[`RET_REG_BIT];
		d.supply_detect_bypass = d.ctrl[`DET_BYPASS_BIT];
		d.voltage_range = d.ctrl[`VRANGE_LSB+:2];
		d.ram_retain = d.ctrl[`BANK_COUNT-1:0] & {`BANK_COUNT{state_a_only}};
		d.pin_wake_irq = any_enabled;
		d.wake_request = any_enabled & q.global_wake & low_power;
	end

	// Only the power-on reset reaches this block; no other reset input exists
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.ctrl <= `CTRL_RESET;
			q.retention_reg_on <= 1'b1;
			q.voltage_range <= 2'h2;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign core_por_block = q.core_por_block;
	assign bandgap_off = q.bandgap_off;
	assign quick_wake = q.quick_wake;
	assign retention_reg_on = q.retention_reg_on;
	assign supply_detect_bypass = q.supply_detect_bypass;
	assign voltage_range = q.voltage_range;
	assign ram_retain = q.ram_retain;
	assign ram_power_off = q.ram_off;
	assign pin_wake_irq = q.pin_wake_irq;
	assign wake_request = q.wake_request;
	assign irq = q.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_ctrl_only_written: assert property (
		!ctrl_wr |=> $stable(q.ctrl))
		else $error("Control word changed without a write");

	chk_por_block_on: assert property (
		(q.ctrl[`POR_BLOCK_BIT] && deep_or_state_a && !ctrl_wr) |=> core_por_block)
		else $error("Core POR not withheld in deep or state_a");

	chk_por_block_off: assert property (
		(!deep_or_state_a || (!q.ctrl[`POR_BLOCK_BIT] && !ctrl_wr)) |=> !core_por_block)
		else $error("Core POR withheld when it should pass");

	chk_bandgap_state: assert property (
		!ctrl_wr |=> (bandgap_off == ($past(q.ctrl[`BANDGAP_BIT]) && $past(deep_or_state_a))))
		else $error("Bandgap off does not follow bit and mode");

	chk_quick_wake: assert property (
		(q.ctrl[`QUICK_WAKE_BIT] && mode == pwr_seq_pkg::PM_DEEP && !ctrl_wr) |=> quick_wake)
		else $error("Quick wake not applied in deep sleep");

	chk_retention_src: assert property (
		!ctrl_wr ##1 !ctrl_wr |-> (retention_reg_on == q.ctrl[`RET_REG_BIT]))
		else $error("Retention source differs from control bit");

	chk_bypass_follow: assert property (
		!ctrl_wr ##1 !ctrl_wr |-> (supply_detect_bypass == q.ctrl[`DET_BYPASS_BIT]))
		else $error("Supply detect bypass differs from control bit");

	chk_vrange_legal: assert property (
		(voltage_range != `VRANGE_RESERVED) && (q.ctrl[`VRANGE_LSB+:2] != `VRANGE_RESERVED))
		else $error("Reserved voltage range reached the regulator");

	chk_ram_retain: assert property (
		(mode == pwr_seq_pkg::PM_STATE_A && !ctrl_wr) |=> (ram_retain == $past(q.ctrl[`BANK_COUNT-1:0])))
		else $error("RAM retention selection not applied in state_a");

	chk_wake_req: assert property (
		(any_enabled && q.global_wake && low_power) |=> wake_request)
		else $error("Enabled pin wake did not request wakeup");

	chk_wake_gate: assert property (
		(!q.global_wake || !low_power) |=> !wake_request)
		else $error("Wake request without global enable or outside low power");

	chk_irq_level: assert property (
		any_enabled |=> pin_wake_irq)
		else $error("Pin wake interrupt not raised for enabled flag");

	chk_irq_drop: assert property (
		!any_enabled |=> !pin_wake_irq)
		else $error("Pin wake interrupt stayed up without enabled flag");

	chk_ram_off: assert property (
		hit(wr_en, addr, `RAM_SHUTDOWN_OFF) |=> (ram_power_off == $past(wdata[`BANK_COUNT-1:0])))
		else $error("RAM power off does not follow write");

	chk_stat_set_wins: assert property (
		(stat_rd && events != '0) |=> ((q.int_stat & $past(events)) == $past(events)))
		else $error("Event lost to status read clear");

	chk_flag_read: assert property (
		hit(rd_en, addr, `FLAG_OFF) |=> (rdata == {{(32-`PIN_COUNT){1'b0}}, $past(wk.flags)}))
		else $error("Flag read data differ from flags");

	chk_rdata_idle: assert property (
		!rd_en |=> (rdata == '0))
		else $error("Read data not zero outside a read");

	chk_ctrl_read: assert property (
		hit(rd_en, addr, `CTRL_OFF) |=> (rdata == $past(q.ctrl)))
		else $error("Control read data differ from control word");

	chk_ram_read: assert property (
		hit(rd_en, addr, `RAM_SHUTDOWN_OFF) |=> (rdata == {{(32-`BANK_COUNT){1'b0}}, $past(q.ram_off)}))
		else $error("RAM shutdown read data differ from register");

	chk_ctrl_reserved_bit: assert property (
		(q.ctrl & ~`CTRL_WMASK) == '0)
		else $error("Read-only control bit became set");

	chk_vrange_keep: assert property (
		(ctrl_wr && wdata[`VRANGE_LSB+:2] == `VRANGE_RESERVED) |=> $stable(q.ctrl[`VRANGE_LSB+:2]))
		else $error("Reserved voltage write changed the range");

	chk_ctrl_write: assert property (
		(ctrl_wr && wdata[`VRANGE_LSB+:2] != `VRANGE_RESERVED) |=> (q.ctrl == ($past(wdata) & `CTRL_WMASK)))
		else $error("Control write not stored");

	chk_wake_en_write: assert property (
		hit(wr_en, addr, `WAKE_EN_OFF) |=> (q.wake_en == $past(wdata)))
		else $error("Pin wake enable write not stored");

	chk_global_write: assert property (
		hit(wr_en, addr, `GLOBAL_WAKE_OFF) |=> (q.global_wake == $past(wdata[0])))
		else $error("Global pin wake enable write not stored");

	chk_mask_write: assert property (
		hit(wr_en, addr, `INT_MASK_OFF) |=> (q.int_mask == $past(wdata[`EVENT_COUNT-1:0])))
		else $error("Interrupt mask write not stored");

	chk_stat_clear: assert property (
		(stat_rd && events == '0) |=> (q.int_stat == '0))
		else $error("Status read did not clear status");

	chk_stat_hold: assert property (
		!stat_rd |=> ((q.int_stat & $past(q.int_stat)) == $past(q.int_stat)))
		else $error("Status bit fell without a read");

	chk_irq_follow: assert property (
		irq == |(q.int_stat & q.int_mask))
		else $error("Interrupt output differs from masked status");

	chk_event_enabled: assert property (
		events[`EV_ENABLED_BIT] |=> q.int_stat[`EV_ENABLED_BIT])
		else $error("Enabled pin toggle not recorded in status");

	chk_wake_needs_flag: assert property (
		!any_enabled |=> !wake_request)
		else $error("Wake request without enabled flag");

	chk_retain_outside_state_a: assert property (
		(mode != pwr_seq_pkg::PM_STATE_A) |=> (ram_retain == '0))
		else $error("RAM retention applied outside state_a");

	chk_quick_wake_off: assert property (
		(mode != pwr_seq_pkg::PM_DEEP) |=> !quick_wake)
		else $error("Quick wake applied outside deep sleep");

	chk_bandgap_on: assert property (
		!deep_or_state_a |=> !bandgap_off)
		else $error("Bandgap switched off outside deep or state_a");

	chk_ram_off_hold: assert property (
		!hit(wr_en, addr, `RAM_SHUTDOWN_OFF) |=> $stable(ram_power_off))
		else $error("RAM power off changed without a write");

	cov_wake_request: cover property (
		$rose(wake_request));
	cov_flag_clear: cover property (
		pin_wake_irq ##1 flag_wr ##[1:3] !pin_wake_irq);
	cov_stat_read: cover property (
		stat_rd && q.int_stat != '0);
	cov_state_a_retain: cover property (
		mode == pwr_seq_pkg::PM_STATE_A && ram_retain != '0);
	cov_quick_wake: cover property (
		quick_wake && mode == pwr_seq_pkg::PM_DEEP);
endmodule

//--- verilog/pwr_seq_defines.svh
// Purpose: Offsets, field positions, reset values of the always-on power sequencer
// Assumes: Byte addresses on an 8-bit register port, 32-bit words
// Notes: Definitions only
//
// What this block does
// - Only power-on reset restores register contents
// - Bit 12 withholds core POR in deep/state_a
// - Bit 11 turns bandgap off in deep/state_a
// - Bit 10 selects quick wake; software sets it
// - Bit 8 selects retention regulator for RAM
// - Bit 6 bypasses external core supply detection
// - Bits 5:4 pick voltage range; 0b11 reserved
// - Bits 3:0 retain RAM banks through state_a
// - Pin toggle sets flag; write 1 clears
// - Flag, pin enable, global enable wake device
// - Pin enable lets flag raise interrupt, wake
// - Pin wake raises dedicated pin-wake interrupt
// - RAM power-off bit removes bank power
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH

`define CTRL_OFF 8'h00
`define FLAG_OFF 8'h04
`define WAKE_EN_OFF 8'h08
`define GLOBAL_WAKE_OFF 8'h0C
`define INT_STAT_OFF 8'h10
`define INT_MASK_OFF 8'h14
`define RAM_SHUTDOWN_OFF 8'h40

`define CTRL_RESET 32'h00001920
`define CTRL_WMASK 32'hFFFFFDFF
`define POR_BLOCK_BIT 12
`define BANDGAP_BIT 11
`define QUICK_WAKE_BIT 10
`define RET_REG_BIT 8
`define DET_BYPASS_BIT 6
`define VRANGE_LSB 4
`define VRANGE_RESERVED 2'h3
`define PIN_COUNT 14
`define BANK_COUNT 4
`define EVENT_COUNT 2
`define EV_TOGGLE_BIT 0
`define EV_ENABLED_BIT 1

`endif

//--- verilog/pwr_seq_pkg.sv
// Purpose: Shared types of the power sequencer
// Assumes: Widths from the defines header
// Notes: No constants live here
`include "pwr_seq_defines.svh"
package pwr_seq_pkg;

	typedef enum logic [1:0] {
		PM_ACTIVE = 2'b00,
		PM_SLEEP = 2'b01,
		PM_DEEP = 2'b10,
		PM_STATE_A = 2'b11
	} power_mode_e;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] wake_en;
		logic global_wake;
		logic [`BANK_COUNT-1:0] ram_off;
		logic [`EVENT_COUNT-1:0] int_stat;
		logic [`EVENT_COUNT-1:0] int_mask;
		logic [31:0] rdata;
		logic core_por_block;
		logic bandgap_off;
		logic quick_wake;
		logic retention_reg_on;
		logic supply_detect_bypass;
		logic [1:0] voltage_range;
		logic [`BANK_COUNT-1:0] ram_retain;
		logic pin_wake_irq;
		logic wake_request;
		logic irq;
	} ctrl_state_s;

endpackage

//--- verilog/wake_flag_bank.sv
// Purpose: Sticky pin wake flags, cleared by writing 1
// Assumes: Clear is a one-cycle mask from the register port
// Notes: A toggle in the clear cycle wins
`timescale 1ns/1ps
module wake_flag_bank #(parameter int PINS = 14) (
	input wire logic clk,
	input wire logic reset_n,
	pin_wake_if.bank wk
);
	typedef struct packed {
		logic [PINS-1:0] flags;
	} flag_state_s;

	flag_state_s q;
	flag_state_s d;

	assign wk.flags = q.flags;

	always_comb begin
		d = q;
		d.flags = (q.flags & ~wk.clr) | wk.toggle;
	end

	// Power-on reset only: no other reset reaches these flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	chk_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
		(wk.toggle != '0) |=> ((q.flags & $past(wk.toggle)) == $past(wk.toggle)))
		else $error("Toggled pin flag not set");
	chk_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> ((~q.flags & $past(q.flags) & ~$past(wk.clr)) == '0))
		else $error("Wake flag fell without a clear");
endmodule
